// *** src/apdc_top.sv ***
// audio port data control: format, word length, polarity, source routing
// and two-slot multiplexing of the capture and playback serial lines
// assumes bit and frame clocks arrive on pins (slave timing) and an apb master
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module apdc_top
(
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   input wire logic bclk_pin,
   input wire logic lrclk_pin,
   input wire logic playback_serial_in,
   output logic capture_serial_out,
   output logic capture_serial_oe,
   // converter side
   input wire logic [23:0] cap_left_word,
   input wire logic [23:0] cap_right_word,
   output logic [23:0] play_left_word,
   output logic [23:0] play_right_word,
   output logic play_word_valid
);
   // ==========================================================
   // registers
   logic [15:0] cap_ctl_r;
   logic [15:0] play_ctl_r;
   logic [31:0] prdata_r;
   logic acc_w;
   logic setup_rd;
   logic addr_ok;
   logic [31:0] rd_nxt;
   logic [9:0] idx_r;
   logic [9:0] len_r;
   logic seen_r;

   assign acc_w = psel && penable && pwrite;
   assign setup_rd = psel && !penable;
   assign addr_ok = (paddr == apdc_pkg::ADDR_CAPTURE) || (paddr == apdc_pkg::ADDR_PLAYBACK)
      || (paddr == apdc_pkg::ADDR_STATUS);
   // zero wait states: the access cycle always completes
   assign pready = penable;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = prdata_r;

   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         apdc_pkg::ADDR_CAPTURE: rd_nxt = {16'h0000, cap_ctl_r};
         apdc_pkg::ADDR_PLAYBACK: rd_nxt = {16'h0000, play_ctl_r};
         apdc_pkg::ADDR_STATUS: rd_nxt = {16'h0000, seen_r, 5'h00, len_r};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         prdata_r <= 32'h0000_0000;
      end
      else if (ce && setup_rd)
      begin
         prdata_r <= rd_nxt;
      end
   end

   // only documented fields are writable, others read zero
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cap_ctl_r <= apdc_pkg::CAP_RESET;
         play_ctl_r <= apdc_pkg::PLAY_RESET;
      end
      else if (ce && acc_w)
      begin
         // each direction has its own slot-mux enable and select
         if (paddr == apdc_pkg::ADDR_CAPTURE)
         begin
            cap_ctl_r <= pwdata[15:0] & apdc_pkg::CAP_MASK;
         end
         if (paddr == apdc_pkg::ADDR_PLAYBACK)
         begin
            play_ctl_r <= pwdata[15:0] & apdc_pkg::PLAY_MASK;
         end
      end
   end

   // ==========================================================
   // pin sampling and edge finding
   logic [2:0] pin_s;
   logic bclk_e;
   logic bclk_prev_r;
   logic lr_e;
   logic lr_prev_r;
   logic is_dsp;
   logic rise;
   logic ev;

   apdc_sync2 #(.W(3)) u_sync
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .d({playback_serial_in, lrclk_pin, bclk_pin}),
      .q(pin_s)
   );

   assign is_dsp = apdc_pkg::apdc_fmt_t'(cap_ctl_r[apdc_pkg::FMT_LSB +: 2])
      == apdc_pkg::FMT_DSP;
   // polarity applies to a received bit clock too
   assign bclk_e = pin_s[0] ^ cap_ctl_r[apdc_pkg::BIT_BCLK_INV];
   // bit 7 is a polarity only outside dsp, where it is the variant
   assign lr_e = pin_s[1] ^ (cap_ctl_r[apdc_pkg::BIT_LR_INV] && !is_dsp);
   assign rise = ce && bclk_e && !bclk_prev_r;
   // dsp frames start on the pulse's rising edge, others on any edge
   assign ev = is_dsp ? (lr_e && !lr_prev_r) : (lr_e != lr_prev_r);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bclk_prev_r <= 1'b0;
      end
      else if (ce)
      begin
         bclk_prev_r <= bclk_e;
      end
   end

   // ==========================================================
   // frame position: index of this edge, predicted index of the next
   logic [9:0] cur_idx;
   logic [9:0] nxt_idx;
   logic nxt_half;
   logic wrap;

   always_comb
   begin
      if (ev)
      begin
         cur_idx = 10'h000;
      end
      else if (idx_r == apdc_pkg::IDX_MAX)
      begin
         cur_idx = idx_r;
      end
      else
      begin
         cur_idx = idx_r + 10'h001;
      end
      // half length (frame length in dsp) is learnt from the previous one, so words are
      // placed right from the second half on; words past the half are cut
      wrap = ({1'b0, cur_idx} + 11'h001) >= {1'b0, len_r};
      nxt_idx = wrap ? 10'h000 : cur_idx + 10'h001;
      nxt_half = (wrap && !is_dsp) ? !lr_e : lr_e;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         idx_r <= 10'h000;
         len_r <= 10'h000;
         seen_r <= 1'b0;
         lr_prev_r <= 1'b0;
      end
      else if (rise)
      begin
         idx_r <= cur_idx;
         lr_prev_r <= lr_e;
         if (ev)
         begin
            len_r <= idx_r + 10'h001;
            seen_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // slot locators, one per direction
   apdc_slot_if cp ();
   apdc_slot_if pl ();

   assign cp.idx = nxt_idx;
   assign cp.half = nxt_half;
   assign cp.len = len_r;
   assign cp.fmt = cap_ctl_r[apdc_pkg::FMT_LSB +: 2];
   assign cp.wl = cap_ctl_r[apdc_pkg::WL_LSB +: 2];
   assign cp.tdm = cap_ctl_r[apdc_pkg::BIT_SLOT_MUX];
   assign cp.sel = cap_ctl_r[apdc_pkg::BIT_SLOT_SEL];
   assign cp.variant = cap_ctl_r[apdc_pkg::BIT_LR_INV];
   assign pl.idx = cur_idx;
   assign pl.half = lr_e;
   assign pl.len = len_r;
   assign pl.fmt = cap_ctl_r[apdc_pkg::FMT_LSB +: 2];
   assign pl.wl = cap_ctl_r[apdc_pkg::WL_LSB +: 2];
   assign pl.tdm = play_ctl_r[apdc_pkg::BIT_SLOT_MUX];
   assign pl.sel = play_ctl_r[apdc_pkg::BIT_SLOT_SEL];
   assign pl.variant = cap_ctl_r[apdc_pkg::BIT_LR_INV];

   apdc_slot_locate u_cap_loc
   (
      .s(cp.locator)
   );
   apdc_slot_locate u_play_loc
   (
      .s(pl.locator)
   );

   // ==========================================================
   // capture transmit: bit set up right after the edge before it is read
   logic [23:0] src_word;
   logic [23:0] tx_sh_r;
   logic cap_real;
   logic dout_r;
   logic oe_r;

   always_comb
   begin
      if (cp.chan)
      begin
         src_word = cap_ctl_r[apdc_pkg::BIT_RIGHT_SRC] ? cap_right_word
            : cap_left_word;
      end
      else
      begin
         src_word = cap_ctl_r[apdc_pkg::BIT_LEFT_SRC] ? cap_right_word
            : cap_left_word;
      end
   end

   // of a slot word only the 24 real bits are driven
   assign cap_real = cp.hit && (cp.k < apdc_pkg::REAL_BITS);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         tx_sh_r <= 24'h000000;
         dout_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else if (rise)
      begin
         if (cp.hit && cp.k == 6'h00)
         begin
            tx_sh_r <= {src_word[22:0], 1'b0};
            dout_r <= src_word[23];
         end
         else if (cap_real)
         begin
            tx_sh_r <= {tx_sh_r[22:0], 1'b0};
            dout_r <= tx_sh_r[23];
         end
         else
         begin
            dout_r <= 1'b0;
         end
         // multiplexed: float outside own real bits; the far senders
         // must keep out of this window
         oe_r <= cp.tdm ? cap_real : !(cp.hit && !cap_real);
      end
   end

   assign capture_serial_out = dout_r;
   assign capture_serial_oe = oe_r;

   // ==========================================================
   // playback receive
   logic pl_real;
   logic [5:0] last_k;
   logic pl_done;
   logic [23:0] rx_sh_r;
   logic [23:0] rx_full;
   logic [23:0] rx_left_r;
   logic [23:0] rx_right_r;
   logic [23:0] play_left_r;
   logic [23:0] play_right_r;
   logic play_valid_r;

   // bits past the 24th are ignored
   assign pl_real = pl.hit && (pl.k < apdc_pkg::REAL_BITS);
   assign last_k = (apdc_pkg::wl_bits(pl.wl) < apdc_pkg::REAL_BITS)
      ? apdc_pkg::wl_bits(pl.wl) - 6'h01 : apdc_pkg::REAL_BITS - 6'h01;
   assign pl_done = rise && pl_real && (pl.k == last_k);
   // short words are msb aligned in the 24-bit converter word
   assign rx_full = {rx_sh_r[22:0], pin_s[2]} << (5'h17 - last_k[4:0]);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rx_sh_r <= 24'h000000;
      end
      else if (rise && pl_real)
      begin
         rx_sh_r <= {rx_sh_r[22:0], pin_s[2]};
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rx_left_r <= 24'h000000;
         rx_right_r <= 24'h000000;
         play_left_r <= 24'h000000;
         play_right_r <= 24'h000000;
         play_valid_r <= 1'b0;
      end
      else if (ce)
      begin
         play_valid_r <= pl_done && pl.chan;
         if (pl_done && !pl.chan)
         begin
            rx_left_r <= rx_full;
         end
         if (pl_done && pl.chan)
         begin
            rx_right_r <= rx_full;
            play_left_r <= play_ctl_r[apdc_pkg::BIT_LEFT_SRC] ? rx_full
               : rx_left_r;
            play_right_r <= play_ctl_r[apdc_pkg::BIT_RIGHT_SRC] ? rx_full
               : rx_left_r;
         end
      end
   end

   assign play_left_word = play_left_r;
   assign play_right_word = play_right_r;
   assign play_word_valid = play_valid_r;

   // ==========================================================
   // checks
   sequence s_cap_word_start;
      rise && cp.tdm && cp.hit && cp.k == 6'h00;
   endsequence

   a_tdm_float_out: assert property (@(posedge clk_sys) disable iff (rst)
      rise && cp.tdm && !cp.hit |=> !capture_serial_oe)
      else $error("capture line driven outside own slot");
   a_real_bits_only: assert property (@(posedge clk_sys) disable iff (rst)
      rise && cp.hit && cp.k >= 6'h18 |=> !capture_serial_oe)
      else $error("capture line driven past real data bits");
   a_slot_word_drive: assert property (@(posedge clk_sys) disable iff (rst)
      s_cap_word_start |=> capture_serial_oe && capture_serial_out == $past(src_word[23]))
      else $error("slot word msb not driven");
   a_left_src_pick: assert property (@(posedge clk_sys) disable iff (rst)
      rise && cp.hit && cp.k == 6'h00 && !cp.chan && cap_ctl_r[15]
      |=> capture_serial_out == $past(cap_right_word[23]))
      else $error("left word not taken from right converter");
   a_reset_values: assert property (@(posedge clk_sys)
      $fell(rst) |-> cap_ctl_r == 16'h4050 && play_ctl_r == 16'h4000)
      else $error("control registers not at reset values");
   a_bclk_invert: assert property (@(posedge clk_sys) disable iff (rst)
      ce && $past(ce) && cap_ctl_r[8] && $fell(pin_s[0]) |-> rise)
      else $error("inverted bit clock edge missed");
   a_play_feed: assert property (@(posedge clk_sys) disable iff (rst)
      play_word_valid |-> play_left_word == (play_ctl_r[15] ? rx_right_r : rx_left_r)
      && play_right_word == (play_ctl_r[14] ? rx_right_r : rx_left_r))
      else $error("converter feed routed wrongly");
   a_dsp_variant: assert property (@(posedge clk_sys) disable iff (rst)
      rise && is_dsp && ev && !(pl.tdm && pl.sel)
      |-> pl.hit == cap_ctl_r[7])
      else $error("dsp first bit on wrong edge");
   a_i2s_msb_late: assert property (@(posedge clk_sys) disable iff (rst)
      rise && pl.fmt == 2'b10 && ev |-> !pl.hit)
      else $error("i2s word starts on first edge");
endmodule

// *** src/apdc_pkg.sv ***
// constants, types and helpers shared by the audio port data-control block
// assumes a 32-bit apb register bus and a 24-bit converter data path
package apdc_pkg;

   // ==========================================================
   // register map (printed index, byte address is four times it)
   localparam logic [7:0] REG_IDX_CAPTURE = 8'h04;
   localparam logic [7:0] REG_IDX_PLAYBACK = 8'h05;
   localparam logic [7:0] REG_IDX_STATUS = 8'h06;
   localparam logic [9:0] ADDR_CAPTURE = {REG_IDX_CAPTURE, 2'b00};
   localparam logic [9:0] ADDR_PLAYBACK = {REG_IDX_PLAYBACK, 2'b00};
   localparam logic [9:0] ADDR_STATUS = {REG_IDX_STATUS, 2'b00};

   // ==========================================================
   // field positions
   localparam int BIT_LEFT_SRC = 15;
   localparam int BIT_RIGHT_SRC = 14;
   localparam int BIT_SLOT_MUX = 13;
   localparam int BIT_SLOT_SEL = 12;
   localparam int BIT_BCLK_INV = 8;
   localparam int BIT_LR_INV = 7;
   localparam int WL_LSB = 5;
   localparam int FMT_LSB = 3;
   localparam int STAT_SEEN = 15;

   // ==========================================================
   // reset values and writable bits
   localparam logic [15:0] CAP_RESET = 16'h4050;
   localparam logic [15:0] PLAY_RESET = 16'h4000;
   localparam logic [15:0] CAP_MASK = 16'hf1f8;
   localparam logic [15:0] PLAY_MASK = 16'hf000;

   // ==========================================================
   // data path sizes
   localparam int IDX_W = 10;
   localparam logic [IDX_W-1:0] IDX_MAX = 10'h3ff;
   localparam logic [5:0] REAL_BITS = 6'h18;

   typedef enum logic [1:0]
   {
      FMT_RJ = 2'b00,
      FMT_LJ = 2'b01,
      FMT_I2S = 2'b10,
      FMT_DSP = 2'b11
   } apdc_fmt_t;

   function automatic logic [5:0] wl_bits(input logic [1:0] wl);
      case (wl)
         2'b00: wl_bits = 6'h10;
         2'b01: wl_bits = 6'h14;
         2'b10: wl_bits = 6'h18;
         default: wl_bits = 6'h20;
      endcase
   endfunction

endpackage

// *** src/apdc_slot_if.sv ***
// bundle between the core and one slot locator
// assumes the core drives the frame position and config, the locator answers
`timescale 1ns/1ps
interface apdc_slot_if;
   logic [9:0] idx;
   logic half;
   logic [9:0] len;
   logic [1:0] fmt;
   logic [1:0] wl;
   logic tdm;
   logic sel;
   logic variant;
   logic hit;
   logic chan;
   logic [5:0] k;

   modport locator
   (
      input idx, half, len, fmt, wl, tdm, sel, variant,
      output hit, chan, k
   );
   modport core
   (
      output idx, half, len, fmt, wl, tdm, sel, variant,
      input hit, chan, k
   );
endinterface

// *** src/apdc_sync2.sv ***
// two-flop synchroniser for pins from outside the system clock domain
// assumes the clock enable freezes both stages
`timescale 1ns/1ps
module apdc_sync2 #(
   parameter int W = 1
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else if (ce)
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// *** src/apdc_slot_locate.sv ***
// finds whether a bit-clock index lies in the programmed word of a slot
// assumes idx counts rising bit edges from the last frame-clock event
`timescale 1ns/1ps
module apdc_slot_locate
(
   // frame position in, slot answer out
   apdc_slot_if.locator s
);
   logic [10:0] w;
   logic [10:0] n_w;
   logic [10:0] s_off;
   logic [10:0] base;
   logic [10:0] start;
   logic [10:0] idx;

   always_comb
   begin
      w = {5'h00, apdc_pkg::wl_bits(s.wl)};
      n_w = s.tdm ? {w[9:0], 1'b0} : w;
      s_off = (s.tdm && s.sel) ? w : 11'h000;
      idx = {1'b0, s.idx};
      base = 11'h000;
      s.chan = ~s.half;
      case (apdc_pkg::apdc_fmt_t'(s.fmt))
         apdc_pkg::FMT_RJ:
         begin
            // group of slots ends on the last edge of the half
            base = ({1'b0, s.len} > n_w) ? {1'b0, s.len} - n_w : 11'h000;
         end
         apdc_pkg::FMT_LJ:
         begin
            base = 11'h000;
         end
         apdc_pkg::FMT_I2S:
         begin
            // msb one edge late, left word while frame clock is low
            base = 11'h001;
            s.chan = s.half;
         end
         apdc_pkg::FMT_DSP:
         begin
            // variant b starts at the first edge, a at the second
            base = s.variant ? 11'h000 : 11'h001;
            s.chan = 1'b0;
            // right channel follows straight after left
            if (idx >= base + n_w)
            begin
               base = base + n_w;
               s.chan = 1'b1;
            end
         end
         default:
         begin
            base = 11'h000;
         end
      endcase
      // slot 1 begins right after slot 0
      start = base + s_off;
      s.hit = (idx >= start) && (idx < start + w);
      s.k = 6'(idx - start);
   end
endmodule

// *** dv/apdc_host_model.sv ***
// far-side host: makes bit and frame clocks, sends playback, checks capture
// assumes the block runs with slave timing; index 0 is the first rising edge
`timescale 1ns/1ps
module apdc_host_model
(
   // link pins
   output logic bclk_pin,
   output logic lrclk_pin,
   output logic playback_serial_in,
   input wire logic capture_serial_out,
   input wire logic capture_serial_oe,
   // setup from the bench
   input wire logic run,
   input wire logic [6:0] half_len,
   input wire logic [1:0] first,
   input wire logic [5:0] wlen,
   input wire logic slot,
   input wire logic mux,
   input wire logic left_lvl,
   input wire logic bclk_inv,
   input wire logic [23:0] tx_left,
   input wire logic [23:0] tx_right,
   // results of the last whole frame
   output logic [23:0] rx_left,
   output logic [23:0] rx_right,
   output logic oe_bad,
   output logic idle,
   output logic [7:0] nframes
);
   logic bclk_int;
   logic [23:0] rx;
   logic bad;
   logic own;
   int p;

   assign bclk_pin = bclk_int ^ bclk_inv;

   initial
   begin
      bclk_int = 1'b0;
      lrclk_pin = 1'b0;
      playback_serial_in = 1'b0;
      oe_bad = 1'b0;
      nframes = 8'h00;
   end

   // ==========================================================
   // frames; the bit clock stands still low between them
   always
   begin
      idle = 1'b1;
      wait (run === 1'b1);
      idle = 1'b0;
      bad = 1'b0;
      for (int h = 0; h < 2; h++)
      begin
         // frame edge only while the bit clock is low
         lrclk_pin = left_lvl ^ h[0];
         rx = 24'h000000;
         for (int i = 0; i < int'(half_len); i++)
         begin
            p = i - int'(first) - (slot ? int'(wlen) : 0);
            own = p >= 0 && p < int'(wlen) && p < 24;
            if (own)
               playback_serial_in = (h == 0) ? tx_left[23-p] : tx_right[23-p];
            else
               playback_serial_in = ~playback_serial_in;
            #80;
            bclk_int = 1'b1;
            if (own)
            begin
               rx[23-p] = capture_serial_out;
               if (capture_serial_oe !== 1'b1)
                  bad = 1'b1;
            end
            else if (mux && capture_serial_oe !== 1'b0)
               bad = 1'b1;
            #80;
            bclk_int = 1'b0;
         end
         if (h == 0)
            rx_left = rx;
         else
            rx_right = rx;
      end
      oe_bad = bad;
      nframes = nframes + 8'h01;
      // short pause lets the bench drop run before another frame starts
      #8;
   end
endmodule

// *** dv/apdc_top_test.sv ***
// self-checking bench for the audio port data-control block
// assumes the host model on the link side; apb master tasks live here
`timescale 1ns/1ps
module apdc_top_test;
   logic clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic bclk_pin, lrclk_pin, playback_serial_in, capture_serial_out, capture_serial_oe;
   logic [23:0] cap_left_word, cap_right_word, play_left_word, play_right_word;
   logic play_word_valid, run, slot, mux, left_lvl, bclk_inv, oe_bad, idle;
   logic [6:0] half_len;
   logic [1:0] first;
   logic [5:0] wlen;
   logic [23:0] tx_left, tx_right, rx_left, rx_right;
   logic [7:0] nframes;
   int n_errors = 0;
   int n_tests = 0;
   int n_valid = 0;

   apdc_top dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bclk_pin(bclk_pin), .lrclk_pin(lrclk_pin),
      .playback_serial_in(playback_serial_in), .capture_serial_out(capture_serial_out),
      .capture_serial_oe(capture_serial_oe), .cap_left_word(cap_left_word),
      .cap_right_word(cap_right_word), .play_left_word(play_left_word),
      .play_right_word(play_right_word), .play_word_valid(play_word_valid));

   apdc_host_model host (.bclk_pin(bclk_pin), .lrclk_pin(lrclk_pin),
      .playback_serial_in(playback_serial_in), .capture_serial_out(capture_serial_out),
      .capture_serial_oe(capture_serial_oe), .run(run), .half_len(half_len), .first(first),
      .wlen(wlen), .slot(slot), .mux(mux), .left_lvl(left_lvl), .bclk_inv(bclk_inv),
      .tx_left(tx_left), .tx_right(tx_right), .rx_left(rx_left), .rx_right(rx_right),
      .oe_bad(oe_bad), .idle(idle), .nframes(nframes));

   always #2 clk_sys = ~clk_sys;

   always @(posedge clk_sys)
      if (play_word_valid === 1'b1)
         n_valid <= n_valid + 1;

   // ==========================================================
   // compare, bus and frame helpers
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [23:0] keep(input logic [23:0] v, input logic [5:0] w);
      keep = (w >= 6'h18) ? v : v & ~(24'hffffff >> w);
   endfunction

   task automatic frames(input int n);
      logic [7:0] start;
      int k;
      start = nframes;
      k = 0;
      run <= 1'b1;
      while (nframes !== start + 8'(n) && k < 40000)
      begin
         @(posedge clk_sys);
         k++;
      end
      run <= 1'b0;
      @(posedge clk_sys);
      while (idle !== 1'b1 && k < 80000)
      begin
         @(posedge clk_sys);
         k++;
      end
      if (k >= 40000)
         n_errors++;
   endtask

   // ==========================================================
   // scenarios
   task automatic regs_case;
      logic [31:0] rd;
      logic err;
      apb(10'h010, 1'b0, 32'h0, rd, err);
      chk_val(rd, 32'h00004050);
      apb(10'h014, 1'b0, 32'h0, rd, err);
      chk_val(rd, 32'h00004000);
      apb(10'h010, 1'b1, 32'hffffffff, rd, err);
      apb(10'h010, 1'b0, 32'h0, rd, err);
      chk_val(rd, 32'h0000f1f8);
      apb(10'h014, 1'b1, 32'hffffffff, rd, err);
      apb(10'h014, 1'b0, 32'h0, rd, err);
      chk_val(rd, 32'h0000f000);
      apb(10'h3fc, 1'b1, 32'h0000ffff, rd, err);
      chk_val({31'h0, err}, 32'h1);
      apb(10'h3fc, 1'b0, 32'h0, rd, err);
      chk_val({err, rd[30:0]}, 32'h80000000);
   endtask

   task automatic link_case(input logic [15:0] cap, input logic [15:0] play,
      input logic [6:0] hl, input logic [1:0] f, input logic [5:0] w, input logic lv,
      input logic bi);
      logic [31:0] rd;
      logic err;
      int v0;
      half_len <= hl;
      first <= f;
      wlen <= w;
      mux <= cap[13];
      slot <= cap[13] & cap[12];
      left_lvl <= lv;
      bclk_inv <= bi;
      apb(10'h010, 1'b1, {16'h0, cap}, rd, err);
      apb(10'h014, 1'b1, {16'h0, play}, rd, err);
      // the first frames after a format change only teach the half length
      frames(3);
      v0 = n_valid;
      frames(1);
      chk_val(rx_left, keep(cap[15] ? cap_right_word : cap_left_word, w));
      chk_val(rx_right, keep(cap[14] ? cap_right_word : cap_left_word, w));
      chk_val(play_left_word, keep(play[15] ? tx_right : tx_left, w));
      chk_val(play_right_word, keep(play[14] ? tx_right : tx_left, w));
      chk_val({31'h0, oe_bad}, 32'h0);
      chk_val({31'h0, n_valid != v0}, 32'h1);
      apb(10'h018, 1'b0, 32'h0, rd, err);
      chk_val(rd, {16'h0000, 6'h20, 10'(hl) << (cap[4:3] == 2'b11)});
   endtask

   task automatic finish_test;
      if (n_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #400000;
      n_errors++;
      finish_test;
   end

   initial
   begin
      clk_sys = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0;
      run = 1'b0;
      half_len = 7'h20;
      first = 2'h0;
      wlen = 6'h10;
      slot = 1'b0;
      mux = 1'b0;
      left_lvl = 1'b1;
      bclk_inv = 1'b0;
      tx_left = 24'h9b2d71;
      tx_right = 24'h36e48c;
      cap_left_word = 24'ha5c3e1;
      cap_right_word = 24'h5e1b97;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      regs_case;
      link_case(16'h4008, 16'h4000, 7'h20, 2'h0, 6'h10, 1'b1, 1'b0);
      link_case(16'h80a8, 16'h8000, 7'h20, 2'h0, 6'h14, 1'b0, 1'b0);
      link_case(16'h7050, 16'h7000, 7'h40, 2'h1, 6'h18, 1'b0, 1'b0);
      link_case(16'h7000, 16'h7000, 7'h22, 2'h2, 6'h10, 1'b1, 1'b0);
      link_case(16'h4098, 16'h4000, 7'h10, 2'h0, 6'h10, 1'b1, 1'b0);
      link_case(16'h6168, 16'h6000, 7'h40, 2'h0, 6'h20, 1'b1, 1'b1);
      finish_test;
   end
endmodule
